// >>> common/bidio_pkg.sv
// package of constants for the bidirectional i/o port
package bidio_pkg;
    // ============================================================
    // widths and reset values
    localparam int PORT_W = 8;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00; // all bits input
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    // read value of the write-only direction register
    localparam logic [7:0] DIR_READ_VAL = 8'h00;
    // direction encoding per bit
    localparam logic DIR_OUT = 1'b1;
    localparam logic DIR_IN = 1'b0;
endpackage

// >>> rtl/bidio_port.sv
// one 8-bit bit-configurable bidirectional i/o port
`timescale 1ns/1ps

// Functional notes
// - pull-up applies only to bits in input mode, ignored in output mode
// - input bit read returns current pin level, not the latch
// - input bit write updates the latch only, pin not driven
// - output bit read returns the latch value
// - output bit write updates latch and latch drives the pin
// - each bit's direction is set independently of others
// - direction register is write-only, reads give no setting
// - after reset every bit is input until software sets output
module bidio_port (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic dir_wr,
    input wire logic dir_rd,
    input wire logic pull_wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    output logic [7:0] pull_en
);

    // ============================================================
    // registers
    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] pull_q;
    logic [7:0] rd_mux;
    logic [7:0] latch_d;
    logic [7:0] dir_d;
    logic [7:0] pull_d;

    // ============================================================
    // next values of the software registers
    // latch only write
    // output write to latch
    // latch takes the byte on a data write, whatever the direction
    always_comb begin
        latch_d = latch_q;
        if (data_wr) begin
            latch_d = wdata;
        end
    end

    // one means output
    // direction takes the byte on a direction write
    always_comb begin
        dir_d = dir_q;
        if (dir_wr) begin
            dir_d = wdata;
        end
    end

    // pull-up setting
    // pull-up control takes the byte on a pull-up write
    always_comb begin
        pull_d = pull_q;
        if (pull_wr) begin
            pull_d = wdata;
        end
    end

    // ============================================================
    // register updates
    // port latch, written in either direction
    // latch only write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            latch_q <= bidio_pkg::LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    // direction register, all inputs after reset
    // reset to input
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dir_q <= bidio_pkg::DIR_RST;
        end else begin
            dir_q <= dir_d;
        end
    end

    // pull-up control register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pull_q <= bidio_pkg::PULL_RST;
        end else begin
            pull_q <= pull_d;
        end
    end

    // ============================================================
    // per-bit pin and read logic
    genvar gi;
    generate
        for (gi = 0; gi < bidio_pkg::PORT_W; gi++) begin : g_bit
            assign rd_mux[gi] = (dir_q[gi] == bidio_pkg::DIR_OUT) ?
                latch_q[gi] : pin_i[gi];
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    pin_o[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                    pull_en[gi] <= 1'b0;
                end else begin
                    pin_o[gi] <= latch_d[gi];
                    pin_oe[gi] <= (dir_d[gi] == bidio_pkg::DIR_OUT);
                    // pull-up masked while the bit drives
                    pull_en[gi] <= pull_d[gi] &
                        (dir_d[gi] == bidio_pkg::DIR_IN);
                end
            end
        end
    endgenerate

    // read data register, one cycle after the read strobe
    // direction write-only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= bidio_pkg::RDATA_RST;
        end else if (data_rd) begin
            rdata <= rd_mux;
        end else if (dir_rd) begin
            rdata <= bidio_pkg::DIR_READ_VAL;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_pull_output_off: assert property (
        (pin_oe & pull_en) == 8'h00)
        else $error("pull-up active on an output bit");
    chk_read_input_pin: assert property (
        data_rd && !dir_wr && !data_wr |=>
        ((rdata ^ $past(pin_i)) & ~$past(dir_q)) == 8'h00)
        else $error("input bit read not pin level");
    chk_write_no_drive: assert property (
        data_wr && !dir_wr && dir_q == 8'h00 |=> pin_oe == 8'h00)
        else $error("input bit driven after data write");
    chk_read_output_latch: assert property (
        data_rd |=> ((rdata ^ $past(latch_q)) & $past(dir_q)) == 8'h00)
        else $error("output bit read not latch");
    chk_write_drives_pin: assert property (
        data_wr |=> pin_o == $past(wdata) ##1 pin_o == latch_q)
        else $error("pin not driven with written latch");
    chk_dir_per_bit: assert property (
        dir_wr |=> pin_oe == $past(wdata))
        else $error("direction bits not independent");
    chk_dir_write_only: assert property (
        dir_rd && !data_rd |=> rdata == 8'h00)
        else $error("direction register readable");
    chk_reset_inputs: assert property (
        $rose(resetn) |-> pin_oe == 8'h00)
        else $error("output enabled out of reset");
    chk_dir_encoding: assert property (
        !dir_wr [*2] |-> pin_oe == dir_q)
        else $error("direction encoding wrong");

    cov_mixed_port: cover property (dir_wr && wdata == 8'h0F);
    cov_pin_read: cover property (data_rd && dir_q == 8'h00);
    cov_latch_read: cover property (data_rd && dir_q == 8'hFF);
    cov_pull_input: cover property (pull_en != 8'h00);
    cov_dir_read: cover property (dir_rd && !data_rd);

    // ============================================================
    // holding and update checks
    chk_rdata_holds: assert property (
        !data_rd && !dir_rd |=> $stable(rdata))
        else $error("read data changed without a read");

    chk_read_priority: assert property (
        data_rd && dir_rd |=> rdata == $past(rd_mux))
        else $error("port read lost to direction read");

    chk_latch_update: assert property (
        data_wr |=> latch_q == $past(wdata))
        else $error("latch not updated by data write");

    chk_latch_keeps: assert property (
        !data_wr |=> $stable(latch_q))
        else $error("latch changed without a write");

    chk_input_undriven: assert property (
        (pin_oe & ~dir_q) == 8'h00)
        else $error("input bit has output enabled");

    chk_pin_latch: assert property (
        pin_o == latch_q)
        else $error("pin value differs from latch");

    chk_pull_follows: assert property (
        !pull_wr && !dir_wr |=>
        pull_en == ($past(pull_q) & ~$past(dir_q)))
        else $error("pull-up not masked by direction");

    chk_pull_write: assert property (
        pull_wr && !dir_wr |=>
        pull_en == ($past(wdata) & ~$past(dir_q)))
        else $error("pull-up write not applied");

    chk_dir_keeps: assert property (
        !dir_wr |=> pin_oe == $past(pin_oe))
        else $error("direction changed without a write");

    chk_reset_quiet: assert property (
        $rose(resetn) |-> rdata == 8'h00 && pull_en == 8'h00)
        else $error("outputs not idle out of reset");

    chk_dir_read_inert: assert property (
        dir_rd && !dir_wr |=> $stable(pin_oe))
        else $error("direction read changed direction");
endmodule

// >>> tb/bidio_pins.sv
// pin-side model: outside drivers, pull-ups and the port's own drive
`timescale 1ns/1ps
module bidio_pins (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_v,
    output logic [7:0] pin_i
);
    // a floating pin without pull-up shows the inverse of the latch
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_v)
        | (~pin_oe & ~ext_en & (pull_en | ~pin_o));
endmodule

// >>> tb/bidio_port_test.sv
// self-checking bench for the bidirectional port
`timescale 1ns/1ps
module bidio_port_test;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic data_wr = 1'b0, data_rd = 1'b0, dir_wr = 1'b0;
    logic dir_rd = 1'b0, pull_wr = 1'b0;
    logic [7:0] wdata = 8'h00, ext_en = 8'hFF, ext_v = 8'h3C;
    logic [7:0] rdata, pin_i, pin_o, pin_oe, pull_en;
    int miscompares = 0, cmp_count = 0;
    // ====================
    // clock and instances
    always #2 sys_clk = ~sys_clk;
    bidio_port u_bidio_port (.sys_clk(sys_clk), .resetn(resetn),
        .data_wr(data_wr), .data_rd(data_rd), .dir_wr(dir_wr),
        .dir_rd(dir_rd), .pull_wr(pull_wr), .wdata(wdata), .rdata(rdata),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en));
    bidio_pins u_bidio_pins (.pin_o(pin_o), .pin_oe(pin_oe),
        .pull_en(pull_en), .ext_en(ext_en), .ext_v(ext_v), .pin_i(pin_i));
    // ====================
    // shared tasks
    task automatic cmp8(input string nm, input logic [7:0] e, a);
        cmp_count++;
        if (a !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", nm, e, a);
        end
    endtask
    // strobes: 10 data_wr, 08 dir_wr, 04 pull_wr, 02 data_rd, 01 dir_rd
    task automatic strobe(input logic [4:0] k, input logic [7:0] d);
        @(negedge sys_clk);
        wdata = d;
        {data_wr, dir_wr, pull_wr, data_rd, dir_rd} = k;
        @(negedge sys_clk);
        {data_wr, dir_wr, pull_wr, data_rd, dir_rd} = 5'h00;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic t_reset;
        cmp8("pin_oe", 8'h00, pin_oe);
        cmp8("pull_en", 8'h00, pull_en);
        strobe(5'h02, 8'h00);
        cmp8("rd pins", 8'h3C, rdata);
        $display("reset test done");
    endtask
    task automatic t_mix;
        ext_v = 8'h5A;
        // direction set by a plain store
        strobe(5'h08, 8'h0F);
        strobe(5'h10, 8'hA5);
        cmp8("pin_oe", 8'h0F, pin_oe);
        cmp8("pin_o", 8'hA5, pin_o);
        cmp8("pin level", 8'h55, pin_i);
        strobe(5'h02, 8'h00);
        cmp8("rd mix", 8'h55, rdata);
        strobe(5'h08, 8'hFF);
        strobe(5'h02, 8'h00);
        cmp8("rd latch", 8'hA5, rdata);
        $display("mixed direction test done");
    endtask
    task automatic t_pull;
        ext_en = 8'h00;
        strobe(5'h08, 8'h0F);
        strobe(5'h04, 8'hFF);
        cmp8("pull_en", 8'hF0, pull_en);
        cmp8("pulled pins", 8'hF5, pin_i);
        strobe(5'h01, 8'h00);
        cmp8("dir read", 8'h00, rdata);
        strobe(5'h08, 8'hFF);
        cmp8("pull_en out", 8'h00, pull_en);
        cmp8("pin_oe", 8'hFF, pin_oe);
        strobe(5'h03, 8'h00);
        cmp8("rd both", 8'hA5, rdata);
        $display("pull-up and direction read test done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        t_reset;
        t_mix;
        t_pull;
        end_sim;
    end
    // watchdog: the tests need well under 100 cycles
    initial begin
        #4000;
        miscompares++;
        end_sim;
    end
endmodule
